// ### core/xdl_core.sv
`include "xdl_defines.svh"

// Behaviour
// [RULE1] Direction load copies the accumulator into port A, B or C direction for operand 5, 6, 7.
// [RULE2] Direction load takes only operands five to seven and changes no status flag.
// [RULE3] Literal XOR combines the 8-bit immediate with the accumulator bitwise.
// [RULE4] Literal XOR writes the accumulator and updates only the zero flag.
// [RULE5] File XOR combines the file register at a 7-bit address with the accumulator.
// [RULE6] File XOR with destination 0 writes the accumulator and leaves the file register alone.
// [RULE7] File XOR with destination 1 writes the file register and leaves the accumulator alone.
// [RULE8] Both XORs set the zero flag when the result is zero and clear it otherwise.
module xdl_core #(
  parameter int W = 8,
  parameter int AW = 7
) (
  // Clock and reset
  input  wire logic          mclk,
  input  wire logic          reset_n,
  input  wire logic          clk_en,
  // Decoded instruction
  input  wire logic          op_valid,
  input  xdl_pkg::xdl_op_t   op_code,
  input  wire logic [W-1:0]  literal,
  input  wire logic [AW-1:0] file_addr,
  input  wire logic          dest_sel,
  input  wire logic [2:0]    dir_sel,
  // File register read data
  input  wire logic [W-1:0]  file_rdata,
  // File register write
  output logic               file_we,
  output logic      [AW-1:0] file_waddr,
  output logic      [W-1:0]  file_wdata,
  // Architectural state
  output logic      [W-1:0]  accumulator,
  output logic               zero_flag,
  output logic      [W-1:0]  port_a_direction,
  output logic      [W-1:0]  port_b_direction,
  output logic      [W-1:0]  port_c_direction,
  output logic               dir_sel_error
);
  typedef struct packed {
    logic [W-1:0]  acc;
    logic          zero;
    logic          fwe;
    logic [AW-1:0] fwaddr;
    logic [W-1:0]  fwdata;
    logic          sel_err;
  } xdl_core_state_t;

  xdl_core_state_t st_reg;
  xdl_core_state_t st_next;
  logic [1:0]      rst_sync_reg;
  logic            rst_n;
  logic            dir_load;
  logic            dir_ok;
  logic [W-1:0]    xor_res;

  assign rst_n = rst_sync_reg[1];

  // Release reset through two flops
  // Kept apart from st_reg: reset by pin
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'h1};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // [RULE2] Operand range check
  assign dir_ok   = dir_sel >= `XDL_SEL_PORT_A && dir_sel <= `XDL_SEL_PORT_C;
  assign dir_load = op_valid && op_code == xdl_pkg::OP_LOAD_DIR && dir_ok;

  // [RULE3] [RULE5] XOR operand mux
  always_comb begin
    if (op_code == xdl_pkg::OP_XOR_LIT) begin
      xor_res = st_reg.acc ^ literal;
    end else begin
      xor_res = st_reg.acc ^ file_rdata;
    end
  end

  always_comb begin
    st_next          = st_reg;
    st_next.fwe      = 1'h0;
    st_next.sel_err  = 1'h0;
    if (op_valid) begin
      case (op_code)
        xdl_pkg::OP_LOAD_DIR: begin
          // [RULE2] No flag change
          st_next.sel_err = !dir_ok;
        end
        xdl_pkg::OP_XOR_LIT: begin
          // [RULE4] [RULE8] Accumulator and zero
          st_next.acc  = xor_res;
          st_next.zero = (xor_res == W'(0));
        end
        xdl_pkg::OP_XOR_FILE: begin
          // [RULE8] Zero flag from result
          st_next.zero = (xor_res == W'(0));
          if (dest_sel == `XDL_DEST_ACC) begin
            // [RULE6] Result to accumulator
            st_next.acc = xor_res;
          end else begin
            // [RULE7] Result to file register
            st_next.fwe    = 1'h1;
            st_next.fwaddr = file_addr;
            st_next.fwdata = xor_res;
          end
        end
        default: begin
          st_next.fwe = 1'h0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg.acc     <= W'(`XDL_ACC_RST);
      st_reg.zero    <= `XDL_ZERO_RST;
      st_reg.fwe     <= 1'h0;
      st_reg.fwaddr  <= '0;
      st_reg.fwdata  <= '0;
      st_reg.sel_err <= 1'h0;
    end else if (clk_en) begin
      st_reg.acc     <= st_next.acc;
      st_reg.zero    <= st_next.zero;
      st_reg.fwe     <= st_next.fwe;
      st_reg.fwaddr  <= st_next.fwaddr;
      st_reg.fwdata  <= st_next.fwdata;
      st_reg.sel_err <= st_next.sel_err;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // [RULE1] Direction registers
  xdl_dir_reg #(.W(W), .SEL(`XDL_SEL_PORT_A)) u_dir_a (
    .mclk (mclk), .rst_n (rst_n), .clk_en (clk_en), .load (dir_load),
    .sel  (dir_sel), .data (st_reg.acc), .q (port_a_direction)
  );
  xdl_dir_reg #(.W(W), .SEL(`XDL_SEL_PORT_B)) u_dir_b (
    .mclk (mclk), .rst_n (rst_n), .clk_en (clk_en), .load (dir_load),
    .sel  (dir_sel), .data (st_reg.acc), .q (port_b_direction)
  );
  xdl_dir_reg #(.W(W), .SEL(`XDL_SEL_PORT_C)) u_dir_c (
    .mclk (mclk), .rst_n (rst_n), .clk_en (clk_en), .load (dir_load),
    .sel  (dir_sel), .data (st_reg.acc), .q (port_c_direction)
  );

  assign accumulator   = st_reg.acc;
  assign zero_flag     = st_reg.zero;
  assign file_we       = st_reg.fwe;
  assign file_waddr    = st_reg.fwaddr;
  assign file_wdata    = st_reg.fwdata;
  assign dir_sel_error = st_reg.sel_err;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  AST_DIR_A_LOAD: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE1]
    clk_en && dir_load && dir_sel == `XDL_SEL_PORT_A
      |=> port_a_direction == $past(st_reg.acc))
    else $error("port A direction not loaded");
  AST_DIR_C_LOAD: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE1]
    clk_en && dir_load && dir_sel == `XDL_SEL_PORT_C
      |=> port_c_direction == $past(st_reg.acc) && $stable(port_a_direction))
    else $error("port C direction not loaded alone");
  AST_DIR_NO_FLAG: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE2]
    clk_en && op_valid && op_code == xdl_pkg::OP_LOAD_DIR
      |=> $stable(zero_flag) && $stable(accumulator) && !file_we)
    else $error("direction load touched state");
  AST_DIR_RANGE: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE2]
    clk_en && op_valid && op_code == xdl_pkg::OP_LOAD_DIR && dir_sel < 3'h5
      |=> dir_sel_error && $stable(port_b_direction))
    else $error("out of range direction load");
  AST_XLIT_ACC: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE3]
    clk_en && op_valid && op_code == xdl_pkg::OP_XOR_LIT
      |=> accumulator == ($past(accumulator) ^ $past(literal)))
    else $error("literal xor result wrong");
  AST_XLIT_NOFILE: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE4]
    clk_en && op_valid && op_code == xdl_pkg::OP_XOR_LIT |=> !file_we)
    else $error("literal xor wrote file");
  AST_XFILE_ACC: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE6]
    clk_en && op_valid && op_code == xdl_pkg::OP_XOR_FILE && !dest_sel
      |=> !file_we && accumulator == ($past(accumulator) ^ $past(file_rdata)))
    else $error("file xor to accumulator wrong");
  AST_XFILE_WB: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE7]
    clk_en && op_valid && op_code == xdl_pkg::OP_XOR_FILE && dest_sel
      |=> file_we && $stable(accumulator) && file_waddr == $past(file_addr)
          && file_wdata == ($past(accumulator) ^ $past(file_rdata)))
    else $error("file xor writeback wrong");
  AST_ZERO: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE8]
    clk_en && op_valid && (op_code == xdl_pkg::OP_XOR_FILE || op_code == xdl_pkg::OP_XOR_LIT)
      |=> zero_flag == ((file_we ? file_wdata : accumulator) == W'(0)))
    else $error("zero flag wrong");
  AST_DIR_B_LOAD: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE1]
    clk_en && dir_load && dir_sel == `XDL_SEL_PORT_B
      |=> port_b_direction == $past(st_reg.acc) && $stable(port_c_direction))
    else $error("port B direction not loaded alone");
  AST_DIR_A_ALONE: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE1]
    clk_en && dir_load && dir_sel == `XDL_SEL_PORT_A
      |=> $stable(port_b_direction) && $stable(port_c_direction))
    else $error("port A load disturbed other directions");
  AST_DIR_OK_PULSE: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE2]
    clk_en && dir_load |=> !dir_sel_error)
    else $error("error pulse on valid direction load");
  AST_DIR_RANGE_AC: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE2]
    clk_en && op_valid && op_code == xdl_pkg::OP_LOAD_DIR && dir_sel < 3'h5
      |=> $stable(port_a_direction) && $stable(port_c_direction))
    else $error("out of range load changed a direction");
  AST_XLIT_NODIR: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE4]
    clk_en && op_valid && op_code == xdl_pkg::OP_XOR_LIT
      |=> $stable(port_a_direction) && $stable(port_b_direction) && !dir_sel_error)
    else $error("literal xor touched direction state");
  AST_XFILE_RESULT: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE5]
    clk_en && op_valid && op_code == xdl_pkg::OP_XOR_FILE
      |=> (file_we ? file_wdata : accumulator) == ($past(accumulator) ^ $past(file_rdata)))
    else $error("file xor result wrong");
  AST_XFILE_NODIR: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE8]
    clk_en && op_valid && op_code == xdl_pkg::OP_XOR_FILE
      |=> $stable(port_b_direction) && !dir_sel_error)
    else $error("file xor touched other state");
endmodule // xdl_core

// ### core/xdl_defines.svh
`ifndef XDL_DEFINES_SVH
`define XDL_DEFINES_SVH

// Direction register selectors
`define XDL_SEL_PORT_A   3'h5
`define XDL_SEL_PORT_B   3'h6
`define XDL_SEL_PORT_C   3'h7
// Destination select values
`define XDL_DEST_ACC     1'h0
`define XDL_DEST_FILE    1'h1
// Reset values
`define XDL_ACC_RST      8'h00
`define XDL_DIR_RST      8'hff
`define XDL_ZERO_RST     1'h0

`endif

// ### core/xdl_pkg.sv
package xdl_pkg;
  typedef enum logic [1:0] {
    OP_NONE,
    OP_LOAD_DIR,
    OP_XOR_LIT,
    OP_XOR_FILE
  } xdl_op_t;
endpackage

// ### core/xdl_dir_reg.sv
`include "xdl_defines.svh"

module xdl_dir_reg #(
  parameter int          W      = 8,
  parameter logic [2:0]  SEL    = `XDL_SEL_PORT_A
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic         clk_en,
  // Load request
  input  wire logic         load,
  input  wire logic [2:0]   sel,
  input  wire logic [W-1:0] data,
  // Stored value
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] val;
  } xdl_dir_state_t;

  xdl_dir_state_t st_reg;
  xdl_dir_state_t st_next;

  always_comb begin
    st_next = st_reg;
    if (load && sel == SEL) begin
      st_next.val = data;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg.val <= W'(`XDL_DIR_RST);
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.val;
endmodule // xdl_dir_reg

// ### test/xdl_file_model.sv
module xdl_file_model (
  // Clock
  input  wire logic       mclk,
  // Read side
  input  wire logic [6:0] file_addr,
  output logic      [7:0] file_rdata,
  // Write side
  input  wire logic       file_we,
  input  wire logic [6:0] file_waddr,
  input  wire logic [7:0] file_wdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [128];
  // Known pattern: address xor 5a
  initial for (int i = 0; i < 128; i++) mem[i] = 8'(i) ^ 8'h5a;
  assign file_rdata = mem[file_addr];
  always @(posedge mclk) if (file_we) mem[file_waddr] <= file_wdata;
endmodule // xdl_file_model

// ### test/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk, reset_n, clk_en, op_valid, dest_sel, file_we, zero_flag, dir_sel_error;
  xdl_pkg::xdl_op_t op_code;
  logic [7:0] literal, file_rdata, file_wdata, accumulator, acc_e;
  logic [7:0] port_a_direction, port_b_direction, port_c_direction;
  logic [6:0] file_addr, file_waddr;
  logic [2:0] dir_sel;
  logic [23:0] dir_all;
  int errors, comparisons;
  assign dir_all = {port_c_direction, port_b_direction, port_a_direction};
  xdl_core u_xdl_core (.mclk(mclk), .reset_n(reset_n), .clk_en(clk_en),
    .op_valid(op_valid), .op_code(op_code), .literal(literal), .file_addr(file_addr),
    .dest_sel(dest_sel), .dir_sel(dir_sel), .file_rdata(file_rdata), .file_we(file_we),
    .file_waddr(file_waddr), .file_wdata(file_wdata), .accumulator(accumulator),
    .zero_flag(zero_flag), .port_a_direction(port_a_direction),
    .port_b_direction(port_b_direction), .port_c_direction(port_c_direction),
    .dir_sel_error(dir_sel_error));
  xdl_file_model u_xdl_file_model (.mclk(mclk), .file_addr(file_addr),
    .file_rdata(file_rdata), .file_we(file_we), .file_waddr(file_waddr),
    .file_wdata(file_wdata));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // One instruction, outputs settled after the taking edge
  task automatic issue(input xdl_pkg::xdl_op_t op, input logic [7:0] k,
                       input logic [6:0] a, input logic d, input logic [2:0] s);
    @(posedge mclk);
    op_valid <= 1'h1;
    op_code  <= op;
    literal  <= k;
    file_addr <= a;
    dest_sel <= d;
    dir_sel  <= s;
    @(posedge mclk);
    op_valid <= 1'h0;
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_lit();
    issue(xdl_pkg::OP_XOR_LIT, 8'h3c, 7'h0, 1'h0, 3'h0);
    check(accumulator, 8'h3c);
    check(8'(zero_flag), 8'h00);
    issue(xdl_pkg::OP_XOR_LIT, 8'h3c, 7'h0, 1'h0, 3'h0);
    check(accumulator, 8'h00);
    check(8'(zero_flag), 8'h01);
    @(posedge mclk);
    clk_en <= 1'h0;
    issue(xdl_pkg::OP_XOR_LIT, 8'h5a, 7'h0, 1'h0, 3'h0);
    check(accumulator, 8'h00);
    check(8'(zero_flag), 8'h01);
    @(posedge mclk);
    clk_en <= 1'h1;
  endtask
  task automatic test_file();
    issue(xdl_pkg::OP_XOR_LIT, 8'h81, 7'h0, 1'h0, 3'h0);
    issue(xdl_pkg::OP_XOR_FILE, 8'h00, 7'h7f, 1'h0, 3'h0);
    check(accumulator, 8'h81 ^ 8'h7f ^ 8'h5a);
    check(8'(file_we), 8'h00);
    issue(xdl_pkg::OP_XOR_FILE, 8'h00, 7'h10, 1'h1, 3'h0);
    check(8'(file_we), 8'h01);
    check(8'(file_waddr), 8'h10);
    check(file_wdata, 8'ha4 ^ 8'h4a);
    check(accumulator, 8'ha4);
    issue(xdl_pkg::OP_XOR_LIT, 8'h4a, 7'h0, 1'h0, 3'h0);
    issue(xdl_pkg::OP_XOR_FILE, 8'h00, 7'h10, 1'h1, 3'h0);
    check(file_wdata, 8'h00);
    check(8'(zero_flag), 8'h01);
    acc_e = 8'hee;
  endtask
  task automatic test_dir();
    for (int s = 5; s < 8; s++) begin
      acc_e = acc_e ^ 8'(s * 17);
      issue(xdl_pkg::OP_XOR_LIT, 8'(s * 17), 7'h0, 1'h0, 3'h0);
      issue(xdl_pkg::OP_LOAD_DIR, 8'h00, 7'h0, 1'h0, 3'(s));
      check(dir_all[(s-5)*8 +: 8], acc_e);
      check(8'(zero_flag), 8'(acc_e == 8'h00));
      check(8'(dir_sel_error), 8'h00);
    end
    issue(xdl_pkg::OP_LOAD_DIR, 8'h00, 7'h0, 1'h0, 3'h4);
    check(8'(dir_sel_error), 8'h01);
    check(port_a_direction, 8'hee ^ 8'h55);
    issue(xdl_pkg::OP_XOR_LIT, 8'haa, 7'h0, 1'h0, 3'h0);
    issue(xdl_pkg::OP_LOAD_DIR, 8'h00, 7'h0, 1'h0, 3'h6);
    check(port_b_direction, 8'h00);
    check(8'(zero_flag), 8'h01);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'h0;
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    #10000;
    errors++;
    results();
  end
  initial begin
    {reset_n, op_valid, dest_sel, literal, file_addr, dir_sel} = '0;
    clk_en = 1'h1;
    op_code = xdl_pkg::OP_NONE;
    repeat (4) @(posedge mclk);
    reset_n <= 1'h1;
    repeat (2) @(posedge mclk);
    #1;
    check(accumulator, 8'h00);
    check(dir_all[7:0], 8'hff);
    test_lit();
    test_file();
    test_dir();
    results();
  end
endmodule // tb_top
